// >>> hdl/fifo_ctrl_pkg.sv
// How it works
// - Mode 0: transmit request low while the transmit side holds no character.
// - Mode 0: receive request low once a received character is held.
// - Mode 1: transmit event raised while any transmit FIFO slot is free.
// - Mode 1: receive event at trigger level; FIFO keeps filling until full.
// - Mode 1: receive event when fill meets the level chosen by control bits 7:6.
// - Level select 00, 01, 10, 11 gives 1, 4, 8, 14 characters.
// - Control bits 5 and 4 are unused and read as zero.
// - Control bit 3 picks transfer mode 0 or 1; reset gives mode 0.
// - Disabled or mode 0: transmit request high after the first character.
// - Disabled or mode 0: receive request high once the receiver is empty.
// - Mode 1: transmit request high only while the transmit FIFO is full.
// - Mode 1: receive request low at trigger or time-out, high when empty.
// - Control bit 2 empties the transmit FIFO and self-clears.
// - Control bit 1 empties the receive FIFO and self-clears.
// - Control bit 0 enables both FIFOs; cleared after reset.
// - Other control bits are only taken when the same write sets bit 0.
// - Interrupt source bits 7:6 read ones while FIFOs are enabled.
package fifo_ctrl_pkg;
    localparam int DEPTH = 16;
    localparam int PW = 4;
    localparam int CW = 5;
    localparam int EVT_W = 3;
    // --------------------------------------------------------------
    // Register map
    // --------------------------------------------------------------
    localparam logic [2:0] ADDR_FIFO_CTRL = 3'h0;
    localparam logic [2:0] ADDR_DATA = 3'h1;
    localparam logic [2:0] ADDR_INT_SOURCE = 3'h2;
    localparam logic [2:0] ADDR_EVT_STATUS = 3'h3;
    localparam logic [2:0] ADDR_EVT_CLEAR = 3'h4;
    localparam logic [2:0] ADDR_EVT_ENABLE = 3'h5;
    localparam int FCR_EN_BIT = 0;
    localparam int FCR_RXCLR_BIT = 1;
    localparam int FCR_TXCLR_BIT = 2;
    localparam int FCR_MODE_BIT = 3;
    localparam int FCR_LVL_LSB = 6;
    localparam int EVT_TX_ROOM = 0;
    localparam int EVT_RX_READY = 1;
    localparam int EVT_RX_TIMEOUT = 2;
    localparam logic [3:0] ISR_NONE = 4'h1;
    localparam logic [3:0] ISR_RX_DATA = 4'h4;
    localparam logic [3:0] ISR_RX_TIMEOUT = 4'hc;
    localparam logic [3:0] ISR_TX_ROOM = 4'h2;
    localparam logic [CW-1:0] CAP_FIFO = 5'h10;
    localparam logic [CW-1:0] CAP_HOLD = 5'h01;
    localparam logic [3:0][CW-1:0] TRIG_TABLE = {5'h0e, 5'h08, 5'h04, 5'h01};
    localparam logic [EVT_W-1:0] EVT_RESET = 3'h0;
    // --------------------------------------------------------------
    // Types
    // --------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } reg_req_s;
    typedef struct packed {
        logic en;
        logic dma_mode;
        logic [1:0] lvl_sel;
    } fcr_s;
    localparam fcr_s FCR_RESET = 4'h0;
    typedef struct packed {
        logic [DEPTH-1:0][7:0] mem;
        logic [PW-1:0] rd;
        logic [PW-1:0] wr;
        logic [CW-1:0] cnt;
    } fifo_s;
    typedef struct packed {
        fcr_s fifo_control;
        fifo_s tx;
        fifo_s rx;
        logic rx_blk;
        logic [EVT_W-1:0] evt_status;
        logic [EVT_W-1:0] evt_enable;
        logic [7:0] rdata;
        logic [7:0] tx_head;
        logic tx_avail;
        logic tx_req_n;
        logic rx_req_n;
        logic irq;
    } state_s;
endpackage

// >>> hdl/uart_fifo_ctrl_dma_ready.sv
`timescale 1ns/10ps
module uart_fifo_ctrl_dma_ready
    import fifo_ctrl_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire reg_req_s bus_req_i,
    output logic [7:0] bus_rdata_o,
    input wire logic tx_pop_i,
    output logic [7:0] tx_data_o,
    output logic tx_avail_o,
    input wire logic rx_push_i,
    input wire logic [7:0] rx_data_i,
    input wire logic rx_timeout_i,
    output logic tx_req_n_o,
    output logic rx_req_n_o,
    output logic irq_o
);
    // --------------------------------------------------------------
    // Step function shared by both FIFOs
    // --------------------------------------------------------------
    function automatic fifo_s fifo_step(
        input fifo_s f,
        input logic push,
        input logic [7:0] din,
        input logic pop,
        input logic clr
    );
        fifo_s r;
        r = f;
        if (push) begin
            r.mem[f.wr] = din;
            r.wr = f.wr + PW'(1);
        end
        if (pop) begin
            r.rd = f.rd + PW'(1);
        end
        r.cnt = f.cnt + CW'(push) - CW'(pop);
        // Clear beats a same-cycle push from the shifter
        if (clr) begin
            r = '0;
        end
        return r;
    endfunction

    state_s q;
    state_s d;

    logic fcr_wr;
    logic data_wr;
    logic data_rd;
    logic m1_q;
    logic [CW-1:0] trig_q;
    logic [CW-1:0] cap_q;
    logic tx_push;
    logic tx_take;
    logic rx_put;
    logic rx_take;
    logic tx_clr;
    logic rx_clr;
    logic m1_d;
    logic [CW-1:0] trig_d;
    logic tx_cond;
    logic rx_cond;
    logic [EVT_W-1:0] evt_set;
    logic [EVT_W-1:0] evt_clr;

    assign fcr_wr = bus_req_i.wr && bus_req_i.addr == ADDR_FIFO_CTRL;
    assign data_wr = bus_req_i.wr && bus_req_i.addr == ADDR_DATA;
    assign data_rd = bus_req_i.rd && bus_req_i.addr == ADDR_DATA;
    assign m1_q = q.fifo_control.en && q.fifo_control.dma_mode;
    assign trig_q = TRIG_TABLE[q.fifo_control.lvl_sel];
    // Disabled FIFOs shrink to a single holding register
    assign cap_q = q.fifo_control.en ? CAP_FIFO : CAP_HOLD;

    // --------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------
    always_comb begin
        d = q;
        tx_push = data_wr && q.tx.cnt < cap_q;
        tx_take = tx_pop_i && q.tx.cnt != 0;
        rx_put = rx_push_i && q.rx.cnt < cap_q;
        rx_take = data_rd && q.rx.cnt != 0;
        tx_clr = 1'b0;
        rx_clr = 1'b0;
        evt_clr = '0;

        if (fcr_wr) begin
            if (bus_req_i.wdata[FCR_EN_BIT]) begin
                d.fifo_control.en = 1'b1;
                d.fifo_control.dma_mode = bus_req_i.wdata[FCR_MODE_BIT];
                d.fifo_control.lvl_sel = bus_req_i.wdata[FCR_LVL_LSB+:2];
                tx_clr = bus_req_i.wdata[FCR_TXCLR_BIT];
                rx_clr = bus_req_i.wdata[FCR_RXCLR_BIT];
            end else begin
                // Other bits are dropped on a disabling write
                d.fifo_control.en = 1'b0;
            end
        end
        if (bus_req_i.wr && bus_req_i.addr == ADDR_EVT_CLEAR) begin
            evt_clr = bus_req_i.wdata[EVT_W-1:0];
        end
        if (bus_req_i.wr && bus_req_i.addr == ADDR_EVT_ENABLE) begin
            d.evt_enable = bus_req_i.wdata[EVT_W-1:0];
        end

        d.tx = fifo_step(q.tx, tx_push, bus_req_i.wdata, tx_take, tx_clr);
        d.rx = fifo_step(q.rx, rx_put, rx_data_i, rx_take, rx_clr);

        m1_d = d.fifo_control.en && d.fifo_control.dma_mode;
        trig_d = TRIG_TABLE[d.fifo_control.lvl_sel];

        // Block flag holds the receive request low until empty
        if (d.rx.cnt == 0) begin
            d.rx_blk = 1'b0;
        end else if (d.rx.cnt >= trig_d || rx_timeout_i) begin
            d.rx_blk = 1'b1;
        end

        if (m1_d) begin
            d.tx_req_n = d.tx.cnt == CAP_FIFO;
            d.rx_req_n = !d.rx_blk;
            tx_cond = d.tx.cnt < CAP_FIFO;
            rx_cond = d.rx.cnt >= trig_d;
        end else begin
            d.tx_req_n = d.tx.cnt != 0;
            d.rx_req_n = d.rx.cnt == 0;
            tx_cond = d.tx.cnt == 0;
            rx_cond = d.rx.cnt != 0;
        end

        evt_set = '0;
        evt_set[EVT_TX_ROOM] = tx_cond;
        evt_set[EVT_RX_READY] = rx_cond;
        evt_set[EVT_RX_TIMEOUT] = rx_timeout_i;
        // Set wins so an event in the clearing cycle survives
        d.evt_status = (q.evt_status & ~evt_clr) | evt_set;
        d.irq = |(d.evt_status & d.evt_enable);
        d.tx_avail = d.tx.cnt != 0;
        d.tx_head = d.tx.mem[d.tx.rd];

        // Read data stand one cycle, zero otherwise
        d.rdata = 8'h00;
        if (bus_req_i.rd) begin
            unique case (bus_req_i.addr)
                ADDR_FIFO_CTRL: begin
                    d.rdata[FCR_EN_BIT] = q.fifo_control.en;
                    d.rdata[FCR_MODE_BIT] = q.fifo_control.dma_mode;
                    d.rdata[FCR_LVL_LSB+:2] = q.fifo_control.lvl_sel;
                end
                ADDR_DATA: begin
                    if (q.rx.cnt != 0) begin
                        d.rdata = q.rx.mem[q.rx.rd];
                    end
                end
                ADDR_INT_SOURCE: begin
                    d.rdata[7:6] = {2{q.fifo_control.en}};
                    if (q.evt_status[EVT_RX_TIMEOUT] && q.evt_enable[EVT_RX_TIMEOUT]) begin
                        d.rdata[3:0] = ISR_RX_TIMEOUT;
                    end else if (q.evt_status[EVT_RX_READY] && q.evt_enable[EVT_RX_READY]) begin
                        d.rdata[3:0] = ISR_RX_DATA;
                    end else if (q.evt_status[EVT_TX_ROOM] && q.evt_enable[EVT_TX_ROOM]) begin
                        d.rdata[3:0] = ISR_TX_ROOM;
                    end else begin
                        d.rdata[3:0] = ISR_NONE;
                    end
                end
                ADDR_EVT_STATUS: begin
                    d.rdata[EVT_W-1:0] = q.evt_status;
                end
                ADDR_EVT_ENABLE: begin
                    d.rdata[EVT_W-1:0] = q.evt_enable;
                end
                default: begin
                    d.rdata = 8'h00;
                end
            endcase
        end
    end

    // --------------------------------------------------------------
    // State register
    // --------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            q <= '0;
            q.fifo_control <= FCR_RESET;
            q.evt_status <= EVT_RESET;
            q.evt_enable <= EVT_RESET;
            q.tx_req_n <= 1'b0;
            q.rx_req_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign bus_rdata_o = q.rdata;
    assign tx_data_o = q.tx_head;
    assign tx_avail_o = q.tx_avail;
    assign tx_req_n_o = q.tx_req_n;
    assign rx_req_n_o = q.rx_req_n;
    assign irq_o = q.irq;

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!arst_n_i);

    sequence s_fcr_write(logic [7:0] v);
        fcr_wr && bus_req_i.wdata == v;
    endsequence

    sequence s_idle_host;
        !bus_req_i.wr && !bus_req_i.rd;
    endsequence

    a_tx_req_m0: assert property (!m1_q && q.tx.cnt == 0 |-> !tx_req_n_o)
        else $error("tx request not low while empty in mode 0");
    a_rx_req_m0: assert property (!m1_q && q.rx.cnt != 0 |-> !rx_req_n_o)
        else $error("rx request not low with data in mode 0");
    a_tx_evt_m1: assert property (m1_q && q.tx.cnt < CAP_FIFO |-> q.evt_status[EVT_TX_ROOM])
        else $error("tx room event missing in mode 1");
    a_rx_evt_trig: assert property (m1_q && q.rx.cnt >= trig_q |-> q.evt_status[EVT_RX_READY])
        else $error("rx trigger event missing");
    a_rx_fill_on: assert property (s_idle_host and (q.fifo_control.en && rx_push_i && q.rx.cnt == trig_q
        && q.rx.cnt < CAP_FIFO) |=> q.rx.cnt == $past(q.rx.cnt) + 5'h01)
        else $error("rx fifo stopped filling at trigger");
    a_trig_decode: assert property (trig_q == (q.fifo_control.lvl_sel == 2'h0 ? 5'h01 : q.fifo_control.lvl_sel == 2'h1 ? 5'h04 :
        q.fifo_control.lvl_sel == 2'h2 ? 5'h08 : 5'h0e))
        else $error("trigger level decode wrong");
    a_fcr_unused: assert property (bus_req_i.rd && bus_req_i.addr == ADDR_FIFO_CTRL
        |=> bus_rdata_o[5:4] == 2'h0 && bus_rdata_o[2:1] == 2'h0)
        else $error("unused control bits read nonzero");
    a_mode_sel: assert property (fcr_wr && bus_req_i.wdata[0] |=> q.fifo_control.dma_mode == $past(bus_req_i.wdata[3]))
        else $error("mode select not taken");
    a_tx_busy_m0: assert property (!m1_q && q.tx.cnt != 0 |-> tx_req_n_o)
        else $error("tx request low with character held");
    a_rx_empty_m0: assert property (!m1_q && q.rx.cnt == 0 |-> rx_req_n_o)
        else $error("rx request low with receiver empty");
    a_tx_full_m1: assert property (m1_q |-> tx_req_n_o == (q.tx.cnt == CAP_FIFO))
        else $error("tx request wrong in mode 1");
    a_rx_hold_m1: assert property (m1_q && $past(m1_q) && $rose(rx_req_n_o) |-> q.rx.cnt == 0)
        else $error("rx request released before fifo empty");
    a_tx_clear: assert property (s_fcr_write(8'h05) |=> q.tx.cnt == 0 && q.tx.rd == q.tx.wr)
        else $error("tx fifo not cleared");
    a_rx_clear: assert property (s_fcr_write(8'h03) |=> q.rx.cnt == 0 ##1 q.rx.cnt <= 5'h01)
        else $error("rx fifo not cleared");
    a_fifo_off: assert property (fcr_wr && !bus_req_i.wdata[0] |=> !q.fifo_control.en)
        else $error("fifo enable not cleared");
    a_fcr_gate: assert property (fcr_wr && !bus_req_i.wdata[0]
        |=> q.fifo_control.dma_mode == $past(q.fifo_control.dma_mode) && q.fifo_control.lvl_sel == $past(q.fifo_control.lvl_sel))
        else $error("control bits taken without enable");
    a_isr_en: assert property (bus_req_i.rd && bus_req_i.addr == ADDR_INT_SOURCE
        |=> bus_rdata_o[7:6] == {2{$past(q.fifo_control.en)}})
        else $error("fifo enabled bits wrong");
    a_fifo_depth: assert property (q.tx.cnt <= CAP_FIFO && q.rx.cnt <= CAP_FIFO)
        else $error("fifo count beyond depth");

    // --------------------------------------------------------------
    // Checks on occupancy, outputs and events
    // --------------------------------------------------------------
    sequence s_timeout_clear;
        bus_req_i.wr && bus_req_i.addr == ADDR_EVT_CLEAR && bus_req_i.wdata[EVT_RX_TIMEOUT];
    endsequence

    sequence s_isr_read;
        bus_req_i.rd && bus_req_i.addr == ADDR_INT_SOURCE;
    endsequence

    sequence s_rx_quiet;
        !data_rd && !fcr_wr;
    endsequence

    a_rdata_idle: assert property (!bus_req_i.rd |=> bus_rdata_o == 8'h00)
        else $error("read data not zero outside a read");
    a_rx_pop_read: assert property (data_rd && q.rx.cnt != 0 && !rx_push_i
        |=> q.rx.cnt == $past(q.rx.cnt) - 5'h01)
        else $error("rx read did not pop");
    a_rx_read_data: assert property (data_rd && q.rx.cnt != 0 |=> bus_rdata_o == $past(q.rx.mem[q.rx.rd]))
        else $error("rx read returned wrong byte");
    a_rx_empty_read: assert property (data_rd && q.rx.cnt == 0 && !rx_push_i
        |=> q.rx.cnt == 0 && bus_rdata_o == 8'h00)
        else $error("rx read on empty fifo misbehaved");
    a_tx_push_in: assert property (data_wr && q.tx.cnt < cap_q && !tx_pop_i
        |=> q.tx.cnt == $past(q.tx.cnt) + 5'h01)
        else $error("tx write not stored");
    a_tx_drop_full: assert property (data_wr && q.tx.cnt == cap_q && !tx_pop_i
        |=> q.tx.cnt == $past(q.tx.cnt))
        else $error("tx write taken while full");
    a_tx_pop_empty: assert property (tx_pop_i && q.tx.cnt == 0 && !data_wr |=> q.tx.cnt == 0)
        else $error("tx pop on empty fifo changed count");
    a_rx_drop_full: assert property (rx_push_i && q.rx.cnt == cap_q and s_rx_quiet
        |=> q.rx.cnt == $past(q.rx.cnt))
        else $error("rx push taken while full");
    a_rx_clr_wins: assert property (s_fcr_write(8'h03) and rx_push_i |=> q.rx.cnt == 0)
        else $error("rx push survived a clear");
    a_tx_avail_lvl: assert property (tx_avail_o == (q.tx.cnt != 0))
        else $error("tx available flag wrong");
    a_tx_head_out: assert property (q.tx.cnt != 0 |-> tx_data_o == q.tx.mem[q.tx.rd])
        else $error("tx head byte wrong");
    a_irq_level: assert property (irq_o == |(q.evt_status & q.evt_enable))
        else $error("interrupt level wrong");
    a_evt_set_wins: assert property (s_timeout_clear and rx_timeout_i |=> q.evt_status[EVT_RX_TIMEOUT])
        else $error("event lost against same cycle clear");
    a_evt_clear: assert property (s_timeout_clear and !rx_timeout_i |=> !q.evt_status[EVT_RX_TIMEOUT])
        else $error("event not cleared");
    a_timeout_evt: assert property (rx_timeout_i |=> q.evt_status[EVT_RX_TIMEOUT])
        else $error("timeout event not recorded");
    a_rx_tmo_req: assert property (m1_q && rx_timeout_i && q.rx.cnt != 0 and s_rx_quiet
        |=> !rx_req_n_o)
        else $error("rx request not low after timeout");
    a_rx_trig_req: assert property (m1_q && q.rx.cnt >= trig_q |-> !rx_req_n_o)
        else $error("rx request not low at trigger");
    a_isr_timeout: assert property (s_isr_read and q.evt_status[EVT_RX_TIMEOUT] && q.evt_enable[EVT_RX_TIMEOUT]
        |=> bus_rdata_o[3:0] == ISR_RX_TIMEOUT)
        else $error("timeout source not reported first");
    a_isr_none: assert property (s_isr_read and (q.evt_status & q.evt_enable) == 3'h0
        |=> bus_rdata_o[3:0] == ISR_NONE)
        else $error("idle interrupt source wrong");
    a_enable_set: assert property (fcr_wr && bus_req_i.wdata[FCR_EN_BIT] |=> q.fifo_control.en)
        else $error("fifo enable not set");
    a_lvl_take: assert property (fcr_wr && bus_req_i.wdata[FCR_EN_BIT]
        |=> q.fifo_control.lvl_sel == $past(bus_req_i.wdata[7:6]))
        else $error("level select not taken");
    a_tx_load_m0: assert property (!m1_q && data_wr && q.tx.cnt == 0 && !tx_pop_i |=> tx_req_n_o)
        else $error("tx request not high after first load");
    a_rx_load_m0: assert property (!m1_q && rx_push_i && q.rx.cnt == 0 && !fcr_wr |=> !rx_req_n_o)
        else $error("rx request not low after first load");
endmodule

// >>> test/shifter_model.sv
`timescale 1ns/10ps
module shifter_model (
    input wire logic core_clk_i,
    output logic tx_pop_o,
    output logic rx_push_o,
    output logic [7:0] rx_data_o,
    output logic rx_timeout_o
);
    // ----------------------------------------------------------
    // Serial side stand-in, one pulse per character
    // ----------------------------------------------------------
    initial begin
        tx_pop_o = 1'b0;
        rx_push_o = 1'b0;
        rx_data_o = 8'h00;
        rx_timeout_o = 1'b0;
    end
    // Gap lets the receiver deliver slowly as well as on every other cycle
    task automatic push(input logic [7:0] b, input int gap);
        repeat (gap) @(posedge core_clk_i);
        @(posedge core_clk_i);
        rx_push_o <= 1'b1;
        rx_data_o <= b;
        @(posedge core_clk_i);
        rx_push_o <= 1'b0;
        // Stale data must not look valid between characters
        rx_data_o <= ~b;
    endtask
    task automatic pop();
        @(posedge core_clk_i);
        tx_pop_o <= 1'b1;
        @(posedge core_clk_i);
        tx_pop_o <= 1'b0;
    endtask
    task automatic timeout();
        @(posedge core_clk_i);
        rx_timeout_o <= 1'b1;
        @(posedge core_clk_i);
        rx_timeout_o <= 1'b0;
    endtask
endmodule

// >>> test/tb_uart_fifo_ctrl_dma_ready.sv
`timescale 1ns/10ps
module tb_uart_fifo_ctrl_dma_ready
    import fifo_ctrl_pkg::*;
;
    localparam int TRIG [4] = '{1, 4, 8, 14};
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    reg_req_s req = '0;
    logic [7:0] rdata, tx_data, rx_data, d;
    logic tx_avail, tx_pop, rx_push, rx_timeout, tx_req_n, rx_req_n, irq;
    int n_fail = 0;
    int n_compared = 0;
    int cycles = 0;

    always #5 clk = ~clk;

    uart_fifo_ctrl_dma_ready uart_fifo_ctrl_dma_ready_i (.core_clk_i(clk), .arst_n_i(arst_n),
        .bus_req_i(req), .bus_rdata_o(rdata), .tx_pop_i(tx_pop), .tx_data_o(tx_data),
        .tx_avail_o(tx_avail), .rx_push_i(rx_push), .rx_data_i(rx_data), .rx_timeout_i(rx_timeout),
        .tx_req_n_o(tx_req_n), .rx_req_n_o(rx_req_n), .irq_o(irq));
    shifter_model shifter_model_i (.core_clk_i(clk), .tx_pop_o(tx_pop), .rx_push_o(rx_push),
        .rx_data_o(rx_data), .rx_timeout_o(rx_timeout));

    // ----------------------------------------------------------
    // Bus access and checking
    // ----------------------------------------------------------
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge clk);
        req <= '0;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        req <= '0;
        #1;
        d = rdata;
    endtask
    // Margin past the one-cycle output register
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        n_compared++;
        if (s !== e) begin
            n_fail++;
            $display("ERROR at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic end_of_test();
        $display("Compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            end_of_test();
        end
    end

    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        settle();
        chk({5'h0, tx_req_n, rx_req_n, irq}, 8'h02);
        rd(ADDR_FIFO_CTRL);
        chk(d, 8'h00);
        rd(ADDR_INT_SOURCE);
        chk(d, 8'h01);
        wr(ADDR_FIFO_CTRL, 8'hfe);
        rd(ADDR_FIFO_CTRL);
        chk(d, 8'h00);
        // Disabled: one-deep holding registers
        wr(ADDR_DATA, 8'h41);
        wr(ADDR_DATA, 8'h42);
        settle();
        chk({tx_avail, 6'h0, tx_req_n}, 8'h81);
        chk(tx_data, 8'h41);
        shifter_model_i.pop();
        settle();
        chk({tx_avail, 6'h0, tx_req_n}, 8'h00);
        shifter_model_i.push(8'h55, 0);
        shifter_model_i.push(8'h66, 0);
        settle();
        chk({7'h0, rx_req_n}, 8'h00);
        rd(ADDR_DATA);
        chk(d, 8'h55);
        settle();
        chk({7'h0, rx_req_n}, 8'h01);
        wr(ADDR_FIFO_CTRL, 8'hf9);
        rd(ADDR_FIFO_CTRL);
        chk(d, 8'hc9);
        rd(ADDR_INT_SOURCE);
        chk(d, 8'hc1);
        // Mode 0 with FIFOs, then both clear bits
        wr(ADDR_FIFO_CTRL, 8'h01);
        repeat (3) shifter_model_i.push(8'h11, 1);
        wr(ADDR_DATA, 8'h21);
        wr(ADDR_DATA, 8'h22);
        settle();
        chk({6'h0, tx_req_n, rx_req_n}, 8'h02);
        wr(ADDR_FIFO_CTRL, 8'h07);
        settle();
        chk({tx_avail, 5'h0, tx_req_n, rx_req_n}, 8'h01);
        rd(ADDR_FIFO_CTRL);
        chk(d, 8'h01);
        // Mode 1 transmit: request only reflects a full FIFO
        wr(ADDR_FIFO_CTRL, 8'h09);
        for (int k = 1; k <= 16; k++) begin
            wr(ADDR_DATA, 8'(k));
            settle();
            chk({7'h0, tx_req_n}, (k == 16) ? 8'h01 : 8'h00);
        end
        wr(ADDR_EVT_CLEAR, 8'h07);
        rd(ADDR_EVT_STATUS);
        chk(d, 8'h00);
        shifter_model_i.pop();
        settle();
        chk({7'h0, tx_req_n}, 8'h00);
        rd(ADDR_EVT_STATUS);
        chk(d, 8'h01);
        // Every trigger level, fill to full and drain
        for (int s = 0; s < 4; s++) begin
            wr(ADDR_FIFO_CTRL, 8'(s << 6) | 8'h0f);
            wr(ADDR_EVT_CLEAR, 8'h07);
            settle();
            chk({7'h0, rx_req_n}, 8'h01);
            for (int k = 1; k <= 16; k++) begin
                shifter_model_i.push(8'(k), k % 3);
                settle();
                rd(ADDR_EVT_STATUS);
                if (k == TRIG[s] - 1)
                    chk({6'h0, d[1], rx_req_n}, 8'h01);
                if (k == TRIG[s])
                    chk({6'h0, d[1], rx_req_n}, 8'h02);
            end
            shifter_model_i.push(8'hee, 0);
            for (int k = 1; k <= 16; k++) begin
                chk({7'h0, rx_req_n}, 8'h00);
                rd(ADDR_DATA);
                chk(d, 8'(k));
                settle();
            end
            chk({7'h0, rx_req_n}, 8'h01);
            rd(ADDR_DATA);
            chk(d, 8'h00);
        end
        // Time-out below trigger, interrupt raise, mask and clear
        wr(ADDR_FIFO_CTRL, 8'hc9);
        wr(ADDR_EVT_CLEAR, 8'h07);
        wr(ADDR_EVT_ENABLE, 8'h04);
        shifter_model_i.push(8'h31, 0);
        shifter_model_i.push(8'h32, 0);
        settle();
        chk({6'h0, rx_req_n, irq}, 8'h02);
        shifter_model_i.timeout();
        settle();
        chk({6'h0, rx_req_n, irq}, 8'h01);
        rd(ADDR_INT_SOURCE);
        chk(d, 8'hcc);
        rd(ADDR_EVT_ENABLE);
        chk(d, 8'h04);
        wr(ADDR_EVT_CLEAR, 8'h04);
        settle();
        chk({7'h0, irq}, 8'h00);
        rd(ADDR_EVT_CLEAR);
        chk(d, 8'h00);
        rd(3'h6);
        chk(d, 8'h00);
        rd(ADDR_DATA);
        rd(ADDR_DATA);
        chk(d, 8'h32);
        settle();
        chk({7'h0, rx_req_n}, 8'h01);
        end_of_test();
    end
endmodule
